/* File: shared/sgm_pkg.sv */
// Package for the data signal modulator: source select widths, reset values
// and the carrier choice type. Assumes one synchronous clock domain.
package sgm_pkg;
    localparam int unsigned SGM_MOD_SEL_W  = 5;
    localparam int unsigned SGM_CAR_SEL_W  = 4;
    localparam int unsigned SGM_N_MOD_SRC  = 32;
    localparam int unsigned SGM_N_CAR_SRC  = 16;
    // Index of the external pin within each source vector
    localparam logic [4:0]  SGM_MOD_PIN_IDX = 5'h00;
    localparam logic [3:0]  SGM_CAR_PIN_IDX = 4'h0;
    // Index that selects the software level as modulation source
    localparam logic [4:0]  SGM_MOD_SW_IDX  = 5'h01;
    localparam logic [4:0]  SGM_MOD_SEL_RST = 5'h00;
    localparam logic [3:0]  SGM_CAR_SEL_RST = 4'h0;
    localparam logic        SGM_BIT_RST     = 1'b0;
    typedef enum logic {SGM_USE_HIGH, SGM_USE_LOW} sgm_car_t;
endpackage

/* File: rtl/sgm_signal_modulator.sv */
// Data signal modulator: mixes a selected carrier with a modulation stream.
// Assumes source vectors are driven by peripherals or pins of this clock.
//
// Overview of operation
// [R1] The output is the AND of the active carrier and the modulation signal.
// [R2] While modulation is high the carrier high signal is the active carrier.
// [R3] While modulation is low the carrier low signal is the active carrier.
// [R4] Each carrier and the modulation come from a peripheral or a pin.
// [R5] Setting the module enable turns the modulator on.
// [R6] With enable clear both carriers are forced to ground.
// [R7] With enable clear the software level drives the modulation input.
// [R8] Clearing enable leaves the stored source selections untouched.
// [R9] Setting enable again reconnects the retained selections.
// [R10] While the output is disabled the pin is held low; here it is held at OUTPUT_INVERT, so high when inverted.
// [R11] High carrier sync delays a high-to-low switch to a carrier fall.
// [R12] Low carrier sync delays a low-to-high switch to a carrier fall.
// [R13] Each carrier may be inverted independently by its invert bit.
// [R14] The output invert bit inverts the modulated output.
// [R15] The path is combinational and its level is readable as status.
`timescale 1ns/1ps
module sgm_signal_modulator
    import sgm_pkg::*;
#(
    parameter int unsigned MOD_W = SGM_N_MOD_SRC,
    parameter int unsigned CAR_W = SGM_N_CAR_SRC
) (
    input  wire logic                     REF_CLK,
    input  wire logic                     NRST,
    input  wire logic                     MODULATOR_ENABLE,
    input  wire logic                     SOFTWARE_MODULATION_LEVEL,
    input  wire logic                     OUTPUT_INVERT,
    input  wire logic                     HIGH_CARRIER_INVERT,
    input  wire logic                     LOW_CARRIER_INVERT,
    input  wire logic                     HIGH_CARRIER_SYNC_ENABLE,
    input  wire logic                     LOW_CARRIER_SYNC_ENABLE,
    input  wire logic [SGM_MOD_SEL_W-1:0] MOD_SOURCE_SELECT,
    input  wire logic [SGM_CAR_SEL_W-1:0] HIGH_SOURCE_SELECT,
    input  wire logic [SGM_CAR_SEL_W-1:0] LOW_SOURCE_SELECT,
    input  wire logic                     SELECT_WRITE,
    input  wire logic [MOD_W-1:0]         MOD_SOURCES,
    input  wire logic [CAR_W-1:0]         CARRIER_SOURCES,
    output logic [SGM_MOD_SEL_W-1:0]      MOD_SELECT_READ,
    output logic [SGM_CAR_SEL_W-1:0]      HIGH_SELECT_READ,
    output logic [SGM_CAR_SEL_W-1:0]      LOW_SELECT_READ,
    output logic                          MODULATED_OUTPUT,
    output logic                          MODULATED_OUTPUT_STATUS
);

    logic [SGM_MOD_SEL_W-1:0] mod_sel_reg;
    logic [SGM_CAR_SEL_W-1:0] high_sel_reg;
    logic [SGM_CAR_SEL_W-1:0] low_sel_reg;
    logic                     carrier_high_signal;
    logic                     carrier_low_signal;
    logic                     modulation_signal;
    logic                     high_picked;
    logic                     low_picked;
    logic                     mod_picked;
    logic                     high_hold;
    logic                     low_hold;
    logic                     pin_level;
    sgm_car_t                 car_reg;
    sgm_car_t                 car_next;
    sgm_car_t                 car_eff;
    logic                     mixed;
    logic                     status_reg;

    // Pick one bit of a source vector; used for both carrier selectors
    function automatic logic pick_car(input logic [CAR_W-1:0] v,
                                      input logic [SGM_CAR_SEL_W-1:0] s);
        pick_car = v[s];
    endfunction

    // Pick the modulation source; the software index bypasses the vector
    function automatic logic pick_mod(input logic [MOD_W-1:0] v,
                                      input logic [SGM_MOD_SEL_W-1:0] s,
                                      input logic sw);
        if (s == SGM_MOD_SW_IDX) begin
            pick_mod = sw;
        end else begin
            pick_mod = v[s];
        end
    endfunction

    // Selections change only on reset or an explicit write, never by enable [R8]
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            mod_sel_reg <= SGM_MOD_SEL_RST;
        end else if (SELECT_WRITE) begin
            mod_sel_reg <= MOD_SOURCE_SELECT;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            high_sel_reg <= SGM_CAR_SEL_RST;
        end else if (SELECT_WRITE) begin
            high_sel_reg <= HIGH_SOURCE_SELECT;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            low_sel_reg <= SGM_CAR_SEL_RST;
        end else if (SELECT_WRITE) begin
            low_sel_reg <= LOW_SOURCE_SELECT;
        end
    end

    assign MOD_SELECT_READ  = mod_sel_reg;
    assign HIGH_SELECT_READ = high_sel_reg;
    assign LOW_SELECT_READ  = low_sel_reg;

    // Source routing; index 0 of each vector is the external pin [R4]
    assign high_picked = pick_car(CARRIER_SOURCES, high_sel_reg)
                         ^ HIGH_CARRIER_INVERT; // [R13]
    assign low_picked  = pick_car(CARRIER_SOURCES, low_sel_reg)
                         ^ LOW_CARRIER_INVERT; // [R13]
    assign mod_picked  = pick_mod(MOD_SOURCES, mod_sel_reg,
                                  SOFTWARE_MODULATION_LEVEL);

    // Grounded carriers also keep the block quiet and cheap
    always_comb begin
        if (MODULATOR_ENABLE) begin // [R5] [R9]
            carrier_high_signal = high_picked;
            carrier_low_signal  = low_picked;
        end else begin
            carrier_high_signal = 1'b0; // [R6]
            carrier_low_signal  = 1'b0; // [R6]
        end
    end

    always_comb begin
        if (MODULATOR_ENABLE) begin // [R5] [R9]
            modulation_signal = mod_picked;
        end else begin
            modulation_signal = SOFTWARE_MODULATION_LEVEL; // [R7]
        end
    end

    // A carrier is held while its sync is on and it is still high
    assign high_hold = HIGH_CARRIER_SYNC_ENABLE & carrier_high_signal;
    assign low_hold  = LOW_CARRIER_SYNC_ENABLE & carrier_low_signal;

    // Carrier choice: follows modulation unless a sync holds the switch.
    // Edges are seen on the clock, so carriers faster than it may be missed.
    always_comb begin
        car_next = car_reg;
        case (car_reg)
            SGM_USE_HIGH: begin
                if (!modulation_signal) begin
                    if (!HIGH_CARRIER_SYNC_ENABLE || !carrier_high_signal) begin
                        car_next = SGM_USE_LOW; // [R11]
                    end
                end
            end
            SGM_USE_LOW: begin
                if (modulation_signal) begin
                    if (!LOW_CARRIER_SYNC_ENABLE || !carrier_low_signal) begin
                        car_next = SGM_USE_HIGH; // [R12]
                    end
                end
            end
            default: car_next = SGM_USE_LOW;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            car_reg <= SGM_USE_LOW;
        end else begin
            car_reg <= car_next;
        end
    end

    // Without sync the switch is immediate, so the path stays combinational
    always_comb begin
        car_eff = car_reg;
        if (modulation_signal) begin
            if (!(car_reg == SGM_USE_LOW && low_hold)) begin
                car_eff = SGM_USE_HIGH; // [R2]
            end
        end else begin
            if (!(car_reg == SGM_USE_HIGH && high_hold)) begin
                car_eff = SGM_USE_LOW; // [R3]
            end
        end
    end

    // Held carrier keeps driving the output until its fall [R1]
    always_comb begin
        if (car_eff == SGM_USE_HIGH) begin
            mixed = carrier_high_signal
                    & (modulation_signal | car_reg == SGM_USE_HIGH);
        end else begin
            mixed = carrier_low_signal & modulation_signal;
        end
    end

    // Pin low while disabled, then optional inversion [R10] [R14] [R15]
    assign pin_level        = MODULATOR_ENABLE & mixed; // [R10]
    assign MODULATED_OUTPUT = pin_level ^ OUTPUT_INVERT; // [R14]

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            status_reg <= SGM_BIT_RST;
        end else begin
            status_reg <= MODULATED_OUTPUT; // [R15]
        end
    end

    assign MODULATED_OUTPUT_STATUS = status_reg;

endmodule

/* File: verification/sgm_signal_modulator_props.sv */
// Port checker for the signal modulator, bound to every instance.
// Assumes mixing checks only hold while both carrier syncs are off.
`timescale 1ns/1ps
module sgm_signal_modulator_props
    import sgm_pkg::*;
#(
    parameter int unsigned MOD_W = SGM_N_MOD_SRC,
    parameter int unsigned CAR_W = SGM_N_CAR_SRC
) (
    input wire logic REF_CLK, NRST, MODULATOR_ENABLE, SELECT_WRITE,
    input wire logic SOFTWARE_MODULATION_LEVEL, OUTPUT_INVERT,
    input wire logic HIGH_CARRIER_INVERT, MODULATED_OUTPUT,
    input wire logic MODULATED_OUTPUT_STATUS,
    input wire logic HIGH_CARRIER_SYNC_ENABLE, LOW_CARRIER_SYNC_ENABLE,
    input wire logic [SGM_MOD_SEL_W-1:0] MOD_SOURCE_SELECT, MOD_SELECT_READ,
    input wire logic [SGM_CAR_SEL_W-1:0] HIGH_SOURCE_SELECT, LOW_SOURCE_SELECT,
    input wire logic [SGM_CAR_SEL_W-1:0] HIGH_SELECT_READ, LOW_SELECT_READ,
    input wire logic [MOD_W-1:0] MOD_SOURCES,
    input wire logic [CAR_W-1:0] CARRIER_SOURCES
);
    logic mod_v, car_h, no_sync, hi_run;
    assign no_sync = !HIGH_CARRIER_SYNC_ENABLE && !LOW_CARRIER_SYNC_ENABLE;
    assign hi_run = MODULATOR_ENABLE && mod_v && car_h
        && !LOW_CARRIER_SYNC_ENABLE;
    logic [12:0] sel_in, sel_rd;
    assign mod_v = (MOD_SELECT_READ == SGM_MOD_SW_IDX) ?
        SOFTWARE_MODULATION_LEVEL : MOD_SOURCES[MOD_SELECT_READ];
    assign car_h = CARRIER_SOURCES[HIGH_SELECT_READ] ^ HIGH_CARRIER_INVERT;
    assign sel_in = {MOD_SOURCE_SELECT, HIGH_SOURCE_SELECT, LOW_SOURCE_SELECT};
    assign sel_rd = {MOD_SELECT_READ, HIGH_SELECT_READ, LOW_SELECT_READ};
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    property p_sel_store; SELECT_WRITE |=> sel_rd == $past(sel_in); endproperty
    a_sel_store: assert property (p_sel_store)
        else $error("select not stored");
    property p_sel_keep; !SELECT_WRITE |=> $stable(sel_rd); endproperty
    a_sel_keep: assert property (p_sel_keep)
        else $error("select changed without write");
    property p_en_rise;
        $rose(MODULATOR_ENABLE) && !$past(SELECT_WRITE) |-> $stable(sel_rd);
    endproperty
    a_en_rise: assert property (p_en_rise)
        else $error("select lost over disable");
    property p_off_pin; !MODULATOR_ENABLE |-> MODULATED_OUTPUT == OUTPUT_INVERT;
    endproperty
    a_off_pin: assert property (p_off_pin)
        else $error("pin not idle while disabled");
    property p_mix_hi;
        MODULATOR_ENABLE && mod_v && no_sync
            |-> MODULATED_OUTPUT == (car_h ^ OUTPUT_INVERT);
    endproperty
    a_mix_hi: assert property (p_mix_hi)
        else $error("high carrier mix wrong");
    property p_mix_lo;
        MODULATOR_ENABLE && !mod_v && no_sync
            |-> MODULATED_OUTPUT == OUTPUT_INVERT;
    endproperty
    a_mix_lo: assert property (p_mix_lo)
        else $error("low carrier mix wrong");
    property p_hi_sync;
        HIGH_CARRIER_SYNC_ENABLE && $past(hi_run) && MODULATOR_ENABLE
            && !mod_v && car_h |-> MODULATED_OUTPUT != OUTPUT_INVERT;
    endproperty
    a_hi_sync: assert property (p_hi_sync)
        else $error("high carrier cut before its fall");
    property p_status; 1'b1 |=> MODULATED_OUTPUT_STATUS == $past(MODULATED_OUTPUT);
    endproperty
    a_status: assert property (p_status)
        else $error("status does not follow pin");
    property p_off_hold;
        !MODULATOR_ENABLE [*2] |-> MODULATED_OUTPUT_STATUS == $past(OUTPUT_INVERT);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("status not idle while disabled");
    c_mix: cover property (MODULATOR_ENABLE && mod_v && car_h);
    c_off: cover property (!MODULATOR_ENABLE && OUTPUT_INVERT);
    c_write: cover property (SELECT_WRITE ##1 MODULATOR_ENABLE);
    c_sync: cover property (HIGH_CARRIER_SYNC_ENABLE && $past(hi_run)
        && !mod_v && car_h);
endmodule
bind sgm_signal_modulator sgm_signal_modulator_props
    #(.MOD_W(MOD_W), .CAR_W(CAR_W)) sgm_chk_u (.REF_CLK, .NRST,
    .MODULATOR_ENABLE, .SELECT_WRITE, .SOFTWARE_MODULATION_LEVEL,
    .OUTPUT_INVERT, .HIGH_CARRIER_INVERT, .MODULATED_OUTPUT,
    .MODULATED_OUTPUT_STATUS, .HIGH_CARRIER_SYNC_ENABLE,
    .LOW_CARRIER_SYNC_ENABLE, .MOD_SOURCE_SELECT, .MOD_SELECT_READ,
    .HIGH_SOURCE_SELECT, .LOW_SOURCE_SELECT, .HIGH_SELECT_READ,
    .LOW_SELECT_READ, .MOD_SOURCES, .CARRIER_SOURCES);

/* File: verification/sgm_src_model.sv */
// Source model: peripheral outputs and pins as free-running patterns.
// Assumes it shares the modulator's clock.
`timescale 1ns/1ps
module sgm_src_model (
    input  wire logic   clk,
    output logic [31:0] mod_src = 32'h0,
    output logic [15:0] car_src = 16'h0
);
    logic [7:0] cnt = 8'h00;
    // Bits run at eight rates, the count repeated across bytes and nibbles under XOR masks
    always @(posedge clk) begin
        cnt <= cnt + 8'h01;
        mod_src <= {4{cnt}} ^ 32'h3c96a5f0;
        car_src <= {cnt[3:0], cnt[7:4], cnt} ^ 16'h9a5c;
    end
endmodule

/* File: verification/tb.sv */
// Bench for the signal modulator: select writes, mixing and disable.
// Assumes the source model drives the peripheral and pin vectors.
`timescale 1ns/1ps
module tb;
    import sgm_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b0, sw = 1'b0, oinv = 1'b0;
    logic hinv = 1'b0, linv = 1'b0, wr = 1'b0, pin, st, prev;
    logic hsy = 1'b0, lsy = 1'b0, cur = 1'b0;
    logic [4:0] ms = 5'h00, mr;
    logic [3:0] hs = 4'h0, ls = 4'h0, hr, lr;
    logic [31:0] msrc;
    logic [15:0] csrc;
    logic [4:0] mt [4] = '{5'h00, 5'h01, 5'h0d, 5'h1f};
    logic [3:0] ct [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
    int n_fail = 0, num_checks = 0;
    always #50 clk = ~clk;
    sgm_src_model src_u (.clk(clk), .mod_src(msrc), .car_src(csrc));
    sgm_signal_modulator dut_u (.REF_CLK(clk), .NRST(nrst),
        .MODULATOR_ENABLE(en), .SOFTWARE_MODULATION_LEVEL(sw),
        .OUTPUT_INVERT(oinv), .HIGH_CARRIER_INVERT(hinv),
        .LOW_CARRIER_INVERT(linv), .HIGH_CARRIER_SYNC_ENABLE(hsy),
        .LOW_CARRIER_SYNC_ENABLE(lsy), .MOD_SOURCE_SELECT(ms),
        .HIGH_SOURCE_SELECT(hs), .LOW_SOURCE_SELECT(ls), .SELECT_WRITE(wr),
        .MOD_SOURCES(msrc), .CARRIER_SOURCES(csrc), .MOD_SELECT_READ(mr),
        .HIGH_SELECT_READ(hr), .LOW_SELECT_READ(lr),
        .MODULATED_OUTPUT(pin), .MODULATED_OUTPUT_STATUS(st));
    // Modulation and both carriers as the rules route them
    function automatic logic [2:0] sig();
        logic m;
        m = (!en || ms == SGM_MOD_SW_IDX) ? sw : msrc[ms];
        return {m, en & (csrc[hs] ^ hinv), en & (csrc[ls] ^ linv)};
    endfunction
    // cur is 1 while the high carrier is the one in use
    function automatic logic f();
        logic m, ch, cl, o;
        {m, ch, cl} = sig();
        o = m ? ((!cur && lsy && cl) | ch) : (cur && hsy && ch);
        return (en & o) ^ oinv;
    endfunction
    task automatic chk(input string nm, input logic [12:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // Inputs move 1 ns after the edge; prev is the pin level at that edge
    task automatic step();
        logic m, ch, cl;
        prev = f();
        {m, ch, cl} = sig();
        if (!nrst)
            cur = 1'b0;
        else if (cur && !m && !(hsy && ch))
            cur = 1'b0;
        else if (!cur && m && !(lsy && cl))
            cur = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic run(input int n);
        repeat (n) begin
            step();
            chk("status", {12'h000, prev}, {12'h000, st});
            chk("pin", {12'h000, f()}, {12'h000, pin});
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (4) step();
        nrst = 1'b1;
        chk("sel_rst", 13'h0000, {mr, hr, lr});
        chk("st_rst", 13'h0000, {12'h000, st});
        for (int i = 0; i < 4; i++) begin
            ms = mt[i];
            hs = ct[i];
            ls = ct[3-i];
            {wr, en, oinv, hinv, linv, sw} =
                {2'b11, i[0], i[1], ~i[0], i[1] ^ i[0]};
            step();
            wr = 1'b0;
            chk("sel", {ms, hs, ls}, {mr, hr, lr});
            run(8);
            en = 1'b0;
            run(4);
            chk("sel_off", {ms, hs, ls}, {mr, hr, lr});
            en = 1'b1;
            run(4);
        end
        ms = SGM_MOD_SW_IDX;
        hs = 4'h1;
        ls = 4'h2;
        {wr, hinv, linv, oinv} = 4'b1000;
        step();
        wr = 1'b0;
        for (int j = 0; j < 16; j++) begin
            {hsy, lsy} = j[3:2];
            sw = ~sw;
            run(3);
        end
        wrap_up();
    end
endmodule
